// ==== scm_pkg.sv ====
package scm_pkg;
   // Reference clock and documented frequency limits
   localparam int unsigned CLK_HZ = 40_000_000;
   localparam int unsigned RC_OSC_HZ = 8_000_000;
   localparam int unsigned EXT_MIN_HZ = 4_000_000;
   localparam int unsigned EXT_MAX_HZ = 16_000_000;
   localparam int unsigned AHB_MAX_HZ = 72_000_000;
   localparam int unsigned APB_FAST_MAX_HZ = 72_000_000;
   localparam int unsigned APB_SLOW_MAX_HZ = 36_000_000;
   localparam int unsigned USB_HZ = 48_000_000;

   // Silence on the external clock longer than this counts as failure
   localparam int unsigned MON_TIMEOUT_NS = 1000;
   localparam int unsigned MON_TIMEOUT_CYC =
      (MON_TIMEOUT_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

   // Register offsets
   localparam int unsigned ADDR_W = 12;
   localparam logic [11:0] ADDR_CTRL = 12'h000;
   localparam logic [11:0] ADDR_CFG = 12'h004;
   localparam logic [11:0] ADDR_STAT = 12'h008;
   localparam logic [11:0] ADDR_IRQ_STAT = 12'h00c;
   localparam logic [11:0] ADDR_IRQ_MASK = 12'h010;

   // Clock source encodings, also the control register value
   typedef enum logic [1:0] {
      SRC_RC = 2'h0,
      SRC_EXT = 2'h1,
      SRC_PLL = 2'h2
   } scm_src_t;
   localparam scm_src_t CTRL_RST = SRC_RC;

   // Configuration register layout, top bit first
   typedef struct packed {
      logic usbEn;
      logic pllSrcExt;
      logic [2:0] apbSlowShift;
      logic [2:0] apbFastShift;
      logic [3:0] ahbShift;
   } scm_cfg_t;
   localparam int unsigned CFG_W = 12;
   localparam logic [11:0] CFG_RST = 12'h000;

   // Interrupt status and mask bit positions
   localparam int unsigned IRQ_W = 3;
   localparam int unsigned IRQ_CLK_FAIL = 0;
   localparam int unsigned IRQ_PLL_READY = 1;
   localparam int unsigned IRQ_PLL_FAIL = 2;
   localparam logic [2:0] IRQ_RST = 3'h0;

   // Status register bit positions
   localparam int unsigned STAT_SRC_LSB = 0;
   localparam int unsigned STAT_SWITCHING = 2;
   localparam int unsigned STAT_PLL_LOCKED = 3;
   localparam int unsigned STAT_USB_ON = 4;
endpackage

// ==== scm_clock_ctrl.sv ====
// The APB register port and the register addresses are this design's own decisions.
`timescale 1ns/10ps
module scm_clock_ctrl #(
   parameter int unsigned TIMEOUT_CYC = scm_pkg::MON_TIMEOUT_CYC
) (
   // Clock, reset, enable
   input wire logic clk,
   input wire logic srst,
   input wire logic ce,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Sampled oscillator levels
   input wire logic rcOscClk,
   input wire logic extFastOscClk,
   input wire logic pllClk,
   input wire logic pllLocked,
   // Derived clocks
   output logic sysClk,
   output logic ahbClk,
   output logic apbFastClk,
   output logic apbSlowClk,
   output logic usbClk,
   // Interrupt
   output logic irq
);

   typedef enum {SW_RUN, SW_STOP_OLD, SW_START_NEW} scm_sw_state_t;

   scm_pkg::scm_src_t ctrlSrc_r, curSrc_r;
   scm_pkg::scm_cfg_t cfg_r;
   scm_sw_state_t swState_r;
   logic gateOn_r, sysClk_r, extPrev_r, pllPrev_r, pllLockPrev_r, usbClk_r;
   logic [2:0] irqStat_r, irqMask_r, domClk_r, domPrev_r, srcLevel, irqEvt, irqClr;
   logic [31:0] prdata_r;
   logic [15:0] quietCnt_r, domCnt_r [3];
   logic [3:0] domShift [3];
   logic wrEn, setupRd, addrHit, extEdge, ctrlUsesExt, curUsesExt, monitorOn, failNow, usbOn;

   ////////////////////////////////////////////////////////////////////////////
   // APB access
   assign pready = ce;
   assign wrEn = psel && penable && pwrite && ce;
   assign setupRd = psel && !penable && ce;
   assign addrHit = (paddr == scm_pkg::ADDR_CTRL) || (paddr == scm_pkg::ADDR_CFG)
      || (paddr == scm_pkg::ADDR_STAT) || (paddr == scm_pkg::ADDR_IRQ_STAT)
      || (paddr == scm_pkg::ADDR_IRQ_MASK);
   assign pslverr = psel && penable && !addrHit;
   assign prdata = prdata_r;

   // Read data captured in setup so it comes from a flip-flop
   always_ff @(posedge clk)
   begin
      if (srst)
         prdata_r <= 32'h0;
      else if (setupRd)
      begin
         case (paddr)
            scm_pkg::ADDR_CTRL: prdata_r <= {30'h0, ctrlSrc_r};
            scm_pkg::ADDR_CFG: prdata_r <= {20'h0, cfg_r};
            scm_pkg::ADDR_STAT: prdata_r <= {27'h0, usbOn, pllLocked,
               (swState_r != SW_RUN), curSrc_r};
            scm_pkg::ADDR_IRQ_STAT: prdata_r <= {29'h0, irqStat_r};
            scm_pkg::ADDR_IRQ_MASK: prdata_r <= {29'h0, irqMask_r};
            default: prdata_r <= 32'h0;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Control and configuration registers
   always_ff @(posedge clk)
   begin
      if (srst)
         ctrlSrc_r <= scm_pkg::CTRL_RST;
      else if (ce)
      begin
         if (failNow)
            ctrlSrc_r <= scm_pkg::SRC_RC;
         else if (wrEn && paddr == scm_pkg::ADDR_CTRL && pwdata[1:0] != 2'h3)
            ctrlSrc_r <= scm_pkg::scm_src_t'(pwdata[1:0]);
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
         cfg_r <= scm_pkg::CFG_RST;
      else if (ce && wrEn && paddr == scm_pkg::ADDR_CFG)
         cfg_r <= pwdata[11:0];
   end

   ////////////////////////////////////////////////////////////////////////////
   // External oscillator supervision
   assign extEdge = extFastOscClk && !extPrev_r;
   assign ctrlUsesExt = (ctrlSrc_r == scm_pkg::SRC_EXT)
      || (ctrlSrc_r == scm_pkg::SRC_PLL && cfg_r.pllSrcExt);
   assign curUsesExt = (curSrc_r == scm_pkg::SRC_EXT)
      || (curSrc_r == scm_pkg::SRC_PLL && cfg_r.pllSrcExt);
   assign monitorOn = ctrlUsesExt || curUsesExt;
   assign failNow = monitorOn && !extEdge && (quietCnt_r == 16'(TIMEOUT_CYC - 1));

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         extPrev_r <= 1'b0;
         quietCnt_r <= 16'h0;
      end
      else if (ce)
      begin
         extPrev_r <= extFastOscClk;
         if (!monitorOn || extEdge || failNow)
            quietCnt_r <= 16'h0;
         else
            quietCnt_r <= quietCnt_r + 16'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Glitch-free source switch
   assign srcLevel = {pllClk, extFastOscClk, rcOscClk};

   // Gate changes only while a source is low, except when a failed external source is cut
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         swState_r <= SW_RUN;
         curSrc_r <= scm_pkg::SRC_RC;
         gateOn_r <= 1'b1;
      end
      else if (ce)
      begin
         case (swState_r)
            SW_RUN:
               // Dead source cut at once; it may stick high
               if (failNow && curUsesExt)
               begin
                  gateOn_r <= 1'b0;
                  swState_r <= SW_START_NEW;
               end
               else if (ctrlSrc_r != curSrc_r)
                  swState_r <= SW_STOP_OLD;
            SW_STOP_OLD:
               if (!srcLevel[curSrc_r] || (failNow && curUsesExt))
               begin
                  gateOn_r <= 1'b0;
                  swState_r <= SW_START_NEW;
               end
            SW_START_NEW:
               if (!srcLevel[ctrlSrc_r])
               begin
                  curSrc_r <= ctrlSrc_r;
                  gateOn_r <= 1'b1;
                  swState_r <= SW_RUN;
               end
            default:
               swState_r <= SW_RUN;
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
         sysClk_r <= 1'b0;
      else if (ce)
         sysClk_r <= gateOn_r && srcLevel[curSrc_r];
   end
   assign sysClk = sysClk_r;

   ////////////////////////////////////////////////////////////////////////////
   // Bus prescalers: AHB from system clock, both APBs from AHB
   // Division ratio is 2^shift; frequency limits are left to software
   assign domShift[0] = cfg_r.ahbShift;
   assign domShift[1] = {1'b0, cfg_r.apbFastShift};
   assign domShift[2] = {1'b0, cfg_r.apbSlowShift};

   genvar d;
   generate
      for (d = 0; d < 3; d++)
      begin : g_dom
         logic srcClk;
         assign srcClk = (d == 0) ? sysClk_r : domClk_r[0];
         always_ff @(posedge clk)
         begin
            if (srst)
            begin
               domPrev_r[d] <= 1'b0;
               domCnt_r[d] <= 16'h0;
               domClk_r[d] <= 1'b0;
            end
            else if (ce)
            begin
               domPrev_r[d] <= srcClk;
               if (srcClk && !domPrev_r[d])
                  domCnt_r[d] <= domCnt_r[d] + 16'h1;
               if (domShift[d] == 4'h0)
                  domClk_r[d] <= srcClk;
               else
                  domClk_r[d] <= domCnt_r[d][domShift[d] - 4'h1];
            end
         end
      end
   endgenerate

   assign ahbClk = domClk_r[0];
   assign apbFastClk = domClk_r[1];
   assign apbSlowClk = domClk_r[2];

   ////////////////////////////////////////////////////////////////////////////
   // USB clock from the PLL, only with the external feed
   // PLL must run from the external oscillator
   assign usbOn = cfg_r.usbEn && cfg_r.pllSrcExt && pllLocked;

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         pllPrev_r <= 1'b0;
         usbClk_r <= 1'b0;
      end
      else if (ce)
      begin
         pllPrev_r <= pllClk;
         if (!usbOn)
            usbClk_r <= 1'b0;
         else if (pllClk && !pllPrev_r)
            usbClk_r <= !usbClk_r;
      end
   end
   assign usbClk = usbClk_r;

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt status, write one to clear, set wins
   always_comb
   begin
      irqEvt = 3'h0;
      irqEvt[scm_pkg::IRQ_CLK_FAIL] = failNow;
      irqEvt[scm_pkg::IRQ_PLL_READY] = pllLocked && !pllLockPrev_r;
      irqEvt[scm_pkg::IRQ_PLL_FAIL] = failNow && cfg_r.pllSrcExt
         && (ctrlSrc_r == scm_pkg::SRC_PLL || curSrc_r == scm_pkg::SRC_PLL);
   end
   assign irqClr = (wrEn && paddr == scm_pkg::ADDR_IRQ_STAT) ? pwdata[2:0] : 3'h0;

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         irqStat_r <= scm_pkg::IRQ_RST;
         pllLockPrev_r <= 1'b0;
      end
      else if (ce)
      begin
         pllLockPrev_r <= pllLocked;
         irqStat_r <= (irqStat_r & ~irqClr) | irqEvt;
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
         irqMask_r <= scm_pkg::IRQ_RST;
      else if (ce && wrEn && paddr == scm_pkg::ADDR_IRQ_MASK)
         irqMask_r <= pwdata[2:0];
   end

   // Only enabled causes reach the line
   assign irq = |(irqStat_r & irqMask_r);

   ////////////////////////////////////////////////////////////////////////////
   // Assertions
   reset_rc_a: assert property (@(posedge clk) srst |=>
      (curSrc_r == scm_pkg::SRC_RC && ctrlSrc_r == scm_pkg::SRC_RC && gateOn_r))
      else $error("Clock source not RC after reset");
   ext_watched_a: assert property (@(posedge clk) disable iff (srst)
      (curSrc_r == scm_pkg::SRC_EXT) |-> monitorOn && quietCnt_r < 16'(TIMEOUT_CYC))
      else $error("External clock in use but unsupervised");
   fallback_rc_a: assert property (@(posedge clk) disable iff (srst)
      (ce && failNow) |=> ctrlSrc_r == scm_pkg::SRC_RC)
      else $error("No fallback to RC after failure");
   fail_irq_a: assert property (@(posedge clk) disable iff (srst)
      (ce && failNow && irqMask_r[scm_pkg::IRQ_CLK_FAIL]) |=> irq)
      else $error("Enabled failure gave no interrupt");
   masked_quiet_a: assert property (@(posedge clk) disable iff (srst)
      (irqMask_r == 3'h0) |-> !irq)
      else $error("Interrupt raised while all masked");
   pll_ready_a: assert property (@(posedge clk) disable iff (srst)
      (ce && $rose(pllLocked) && pllLockPrev_r == 1'b0) |=> irqStat_r[scm_pkg::IRQ_PLL_READY])
      else $error("PLL lock not flagged");
   ahb_pass_a: assert property (@(posedge clk) disable iff (srst)
      (ce && cfg_r.ahbShift == 4'h0) |=> ahbClk == $past(sysClk_r))
      else $error("Undivided AHB clock does not follow system clock");
   usb_gate_a: assert property (@(posedge clk) disable iff (srst)
      (ce && !cfg_r.pllSrcExt) |=> !usbClk)
      else $error("USB clock runs without external PLL feed");
   sticky_fail_a: assert property (@(posedge clk) disable iff (srst)
      (irqStat_r[scm_pkg::IRQ_CLK_FAIL] && !irqClr[scm_pkg::IRQ_CLK_FAIL])
      |=> irqStat_r[scm_pkg::IRQ_CLK_FAIL])
      else $error("Failure flag lost without clear");
   gate_low_a: assert property (@(posedge clk) disable iff (srst)
      ($rose(gateOn_r) || ($fell(gateOn_r) && !$past(failNow))) |-> !sysClk_r)
      else $error("System clock gated while high");
   dead_cut_a: assert property (@(posedge clk) disable iff (srst)
      (ce && failNow && curUsesExt && swState_r != SW_START_NEW) |=> !gateOn_r)
      else $error("Failed external source still gated on");
   fallback_c: cover property (@(posedge clk) disable iff (srst)
      failNow ##[1:20] (curSrc_r == scm_pkg::SRC_RC && swState_r == SW_RUN));
   switch_ext_c: cover property (@(posedge clk) disable iff (srst)
      (swState_r == SW_START_NEW) ##1 (curSrc_r == scm_pkg::SRC_EXT));
   pll_ready_c: cover property (@(posedge clk) disable iff (srst)
      $rose(irqStat_r[scm_pkg::IRQ_PLL_READY]));
endmodule

// ==== scm_osc_model.sv ====
`timescale 1ns/10ps
module scm_osc_model (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Scenario controls
   input wire logic extRun,
   input wire logic pllRun,
   // Oscillator levels
   output logic rcOscClk,
   output logic extFastOscClk,
   output logic pllClk,
   output logic pllLocked
);
   logic [2:0] rcCnt_r;
   logic [1:0] extCnt_r;
   logic [3:0] lockCnt_r;
   ////////////////////////////////////////////////////////////////
   // RC source, five cycles
   always_ff @(posedge clk)
   begin
      rcCnt_r <= (srst || rcCnt_r == 3'h4) ? 3'h0 : rcCnt_r + 3'h1;
   end
   assign rcOscClk = rcCnt_r >= 3'h3;
   // External source at 10 MHz
   // A stopped source freezes at its level, as a dead crystal would
   always_ff @(posedge clk)
   begin
      if (srst)
         extCnt_r <= 2'h0;
      else if (extRun)
         extCnt_r <= extCnt_r + 2'h1;
   end
   assign extFastOscClk = extCnt_r[1];
   ////////////////////////////////////////////////////////////////
   // Lock reported some cycles after the PLL starts
   always_ff @(posedge clk)
   begin
      if (srst || !pllRun)
      begin
         pllClk <= 1'b0;
         lockCnt_r <= 4'h0;
      end
      else
      begin
         pllClk <= !pllClk;
         lockCnt_r <= (lockCnt_r == 4'hf) ? lockCnt_r : lockCnt_r + 4'h1;
      end
   end
   assign pllLocked = lockCnt_r == 4'hf;
endmodule

// ==== testbench.sv ====
`timescale 1ns/10ps
module testbench;
   logic clk, srst, ce, psel, penable, pwrite, extRun, pllRun;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic pready, pslverr, rcOscClk, extFastOscClk, pllClk, pllLocked;
   logic sysClk, ahbClk, apbFastClk, apbSlowClk, usbClk, irq, rcPrev, err;
   logic [4:0] prevClk;
   int cnt[5];
   int n_errors = 0;
   int checks_done = 0;
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // Short timeout keeps the failure scenarios quick
   scm_clock_ctrl #(.TIMEOUT_CYC(8)) dut (.clk(clk), .srst(srst), .ce(ce),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .rcOscClk(rcOscClk), .extFastOscClk(extFastOscClk), .pllClk(pllClk),
      .pllLocked(pllLocked), .sysClk(sysClk), .ahbClk(ahbClk),
      .apbFastClk(apbFastClk), .apbSlowClk(apbSlowClk), .usbClk(usbClk), .irq(irq));
   scm_osc_model osc (.clk(clk), .srst(srst), .extRun(extRun), .pllRun(pllRun),
      .rcOscClk(rcOscClk), .extFastOscClk(extFastOscClk), .pllClk(pllClk),
      .pllLocked(pllLocked));
   ////////////////////////////////////////////////////////////////
   task check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      checks_done++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask
   task final_report;
      $display("checks %0d, mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1)
         check(pready, 1'b1, "apb ready timeout");
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task rdchk(input logic [11:0] a, input logic [31:0] exp, input string msg);
      apb(1'b0, a, 32'h0);
      check(rd, exp, msg);
   endtask
   task wait_irq;
      int n;
      n = 0;
      while (irq !== 1'b1 && n < 60)
      begin
         @(posedge clk);
         n++;
      end
   endtask
   // Rising edges of the derived clocks over n cycles
   task count_clk(input int n);
      logic [4:0] lvl;
      for (int i = 0; i < 5; i++)
         cnt[i] = 0;
      prevClk = {usbClk, apbSlowClk, apbFastClk, ahbClk, sysClk};
      repeat (n)
      begin
         @(posedge clk);
         lvl = {usbClk, apbSlowClk, apbFastClk, ahbClk, sysClk};
         for (int i = 0; i < 5; i++)
            if (lvl[i] && !prevClk[i])
               cnt[i]++;
         prevClk = lvl;
      end
   endtask
   // Edge counts of unaligned clocks may differ by one
   function automatic logic near(input int a, input int b);
      return (a - b <= 1) && (b - a <= 1);
   endfunction
   ////////////////////////////////////////////////////////////////
   initial
   begin
      #(25 * 20000);
      n_errors++;
      final_report;
   end
   initial
   begin
      srst = 1'b1;
      ce = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      extRun = 1'b1;
      pllRun = 1'b0;
      prevClk = 5'h00;
      repeat (12) @(posedge clk);
      srst <= 1'b0;
      rdchk(scm_pkg::ADDR_CTRL, 32'h0, "ctrl reset");
      rdchk(scm_pkg::ADDR_CFG, 32'h0, "cfg reset");
      rdchk(scm_pkg::ADDR_STAT, 32'h0, "stat reset");
      rdchk(scm_pkg::ADDR_IRQ_STAT, 32'h0, "flags reset");
      rdchk(scm_pkg::ADDR_IRQ_MASK, 32'h0, "mask reset");
      apb(1'b0, 12'h020, 32'h0);
      check(err, 1'b1, "unmapped error");
      check(rd, 32'h0, "unmapped data");
      repeat (10)
      begin
         @(posedge clk);
         rcPrev = rcOscClk;
         @(negedge clk);
         check(sysClk, rcPrev, "core on rc");
      end
      $display("test reset done");
      apb(1'b1, scm_pkg::ADDR_CTRL, 32'h1);
      repeat (20) @(posedge clk);
      rdchk(scm_pkg::ADDR_STAT, 32'h1, "ext active");
      apb(1'b1, scm_pkg::ADDR_CTRL, 32'h3);
      rdchk(scm_pkg::ADDR_CTRL, 32'h1, "bad source kept");
      apb(1'b1, scm_pkg::ADDR_IRQ_MASK, 32'h1);
      extRun <= 1'b0;
      wait_irq;
      check(irq, 1'b1, "fail irq");
      rdchk(scm_pkg::ADDR_CTRL, 32'h0, "fallback ctrl");
      rdchk(scm_pkg::ADDR_IRQ_STAT, 32'h1, "fail flag");
      repeat (20) @(posedge clk);
      rdchk(scm_pkg::ADDR_STAT, 32'h0, "rc active");
      apb(1'b1, scm_pkg::ADDR_IRQ_STAT, 32'h1);
      rdchk(scm_pkg::ADDR_IRQ_STAT, 32'h0, "flag cleared");
      check(irq, 1'b0, "irq cleared");
      $display("test fallback done");
      apb(1'b1, scm_pkg::ADDR_IRQ_MASK, 32'h0);
      extRun <= 1'b1;
      apb(1'b1, scm_pkg::ADDR_CTRL, 32'h1);
      repeat (20) @(posedge clk);
      extRun <= 1'b0;
      repeat (30) @(posedge clk);
      check(irq, 1'b0, "masked irq");
      rdchk(scm_pkg::ADDR_IRQ_STAT, 32'h1, "masked flag");
      apb(1'b1, scm_pkg::ADDR_IRQ_STAT, 32'h1);
      $display("test masked done");
      extRun <= 1'b1;
      pllRun <= 1'b1;
      // AHB 4 MHz, APBs 2 MHz, far under limits
      apb(1'b1, scm_pkg::ADDR_CFG, 32'h0000_0c91);
      repeat (40) @(posedge clk);
      rdchk(scm_pkg::ADDR_STAT, 32'h18, "pll usb on");
      rdchk(scm_pkg::ADDR_IRQ_STAT, 32'h2, "pll ready");
      count_clk(400);
      check(near(cnt[0], 80), 1'b1, "sys rate");
      check(near(cnt[1], cnt[0] / 2), 1'b1, "ahb div");
      check(near(cnt[2], cnt[1] / 2), 1'b1, "fast div");
      check(near(cnt[3], cnt[1] / 2), 1'b1, "slow div");
      check(near(cnt[4], 100), 1'b1, "usb rate");
      apb(1'b1, scm_pkg::ADDR_IRQ_MASK, 32'h4);
      apb(1'b1, scm_pkg::ADDR_CTRL, 32'h2);
      repeat (20) @(posedge clk);
      rdchk(scm_pkg::ADDR_STAT, 32'h1a, "pll active");
      extRun <= 1'b0;
      wait_irq;
      check(irq, 1'b1, "pll feed irq");
      rdchk(scm_pkg::ADDR_IRQ_STAT, 32'h7, "pll flags");
      rdchk(scm_pkg::ADDR_CTRL, 32'h0, "pll fallback");
      $display("test pll done");
      final_report;
   end
endmodule
